// ---- rtl/sad_pkg.sv ----
// Purpose: shared types and constants for the address and flag decoder
// Assumes: 32-bit addressing, mod r/m byte with s-i-b present
// Notes:   clock figures are core clocks with zero wait states
package sad_pkg;

    // legacy segment selector codes
    typedef enum logic [1:0] {
        SAD_SEG_ES = 2'h0,
        SAD_SEG_CS = 2'h1,
        SAD_SEG_SS = 2'h2,
        SAD_SEG_DS = 2'h3
    } sad_seg_t;

    // flag treatment per instruction
    typedef enum logic [1:0] {
        SAD_FL_KEEP = 2'h0,
        SAD_FL_MOD  = 2'h1,
        SAD_FL_CLR  = 2'h2,
        SAD_FL_SET  = 2'h3
    } sad_flact_t;

    // instruction classes recognised
    typedef enum logic [3:0] {
        SAD_OP_NONE    = 4'h0,
        SAD_OP_AFADD   = 4'h1,
        SAD_OP_AFMUL   = 4'h2,
        SAD_OP_AFDIV   = 4'h3,
        SAD_OP_RPLADJ  = 4'h4,
        SAD_OP_BOUND   = 4'h5,
        SAD_OP_FSCAN   = 4'h6,
        SAD_OP_BCP_IMM = 4'h7,
        SAD_OP_BCP_REG = 4'h8,
        SAD_OP_CALL_N  = 4'h9,
        SAD_OP_CALL_I  = 4'hA,
        SAD_OP_CALL_F  = 4'hB,
        SAD_OP_JCC     = 4'hC
    } sad_op_t;

    // decode request from prefetch
    typedef struct packed {
        logic [7:0]  op0;
        logic [7:0]  op1;
        logic [7:0]  modrm;
        logic [7:0]  sib;
        logic [31:0] disp;
        logic [31:0] base_val;
        logic [31:0] index_val;
        logic        ovr_valid;
        sad_seg_t    ovr_seg;
        logic        prot_mode;
        logic        br_taken;
        logic        odd_addr;
        logic        rmw;
        logic        cache_hit;
        logic        locked;
        logic [5:0]  scan_n;
        logic        bound_out;
    } sad_req_t;

    // per-flag action set
    typedef struct packed {
        sad_flact_t ovf_a;
        sad_flact_t sgn_a;
        sad_flact_t zro_a;
        sad_flact_t aux_a;
        sad_flact_t par_a;
        sad_flact_t cry_a;
    } sad_flags_t;

    // decode result to execution and segmentation
    typedef struct packed {
        logic [31:0] eff_addr;
        sad_seg_t    seg;
        sad_op_t     op;
        sad_flags_t  flags;
        logic [7:0]  clocks;
        logic        raise_int5;
        logic        ea_undef;
    } sad_rsp_t;

    // field codes
    localparam logic [2:0] SAD_IDX_NONE  = 3'h4;
    localparam logic [2:0] SAD_BASE_ESP  = 3'h4;
    localparam logic [2:0] SAD_BASE_EBP  = 3'h5;
    localparam logic [1:0] SAD_MOD_NODSP = 2'h0;
    localparam logic [1:0] SAD_MOD_D8    = 2'h1;
    localparam logic [1:0] SAD_MOD_D32   = 2'h2;
    localparam logic [1:0] SAD_MOD_REG   = 2'h3;

    // clock counts
    localparam logic [7:0] SAD_CK_AFADD   = 8'h04;
    localparam logic [7:0] SAD_CK_AFMUL   = 8'h10;
    localparam logic [7:0] SAD_CK_AFDIV   = 8'h04;
    localparam logic [7:0] SAD_CK_RPL_R   = 8'h06;
    localparam logic [7:0] SAD_CK_RPL_M   = 8'h0A;
    localparam logic [7:0] SAD_CK_BOUND   = 8'h0B;
    localparam logic [7:0] SAD_CK_SCAN_R  = 8'h05;
    localparam logic [7:0] SAD_CK_SCAN_M  = 8'h07;
    localparam logic [7:0] SAD_CK_BTCI_R  = 8'h04;
    localparam logic [7:0] SAD_CK_BTCI_M  = 8'h05;
    localparam logic [7:0] SAD_CK_BTCR_R  = 8'h05;
    localparam logic [7:0] SAD_CK_BTCR_M  = 8'h08;
    localparam logic [7:0] SAD_CK_CALLN   = 8'h07;
    localparam logic [7:0] SAD_CK_CALLI_R = 8'h08;
    localparam logic [7:0] SAD_CK_CALLI_M = 8'h09;
    localparam logic [7:0] SAD_CK_CALLF_R = 8'h0C;
    localparam logic [7:0] SAD_CK_CALLF_P = 8'h1E;
    localparam logic [7:0] SAD_CK_JCC_T   = 8'h04;
    localparam logic [7:0] SAD_CK_JCC_N   = 8'h01;
    localparam logic [7:0] SAD_CK_TWOREG  = 8'h01;
    localparam logic [7:0] SAD_CK_ODD_RW1 = 8'h01;
    localparam logic [7:0] SAD_CK_ODD_RMW = 8'h02;
    localparam logic [7:0] SAD_CK_NOCACHE = 8'h02;

    // reset values
    localparam logic [31:0] SAD_RST_ADDR = 32'h0000_0000;
    localparam logic [7:0]  SAD_RST_CK   = 8'h00;

endpackage

// ---- rtl/sad_decode.sv ----
// Purpose: s-i-b address recipe plus flag and clock decode for one instruction
// Assumes: one request per valid cycle, answer one cycle later
// Notes:   no registers reachable by software
// Operation
// - two-bit selector picks ES CS SS DS
// - scale code multiplies index by 1,2,4,8
// - index code selects register, 100 none
// - mod 00: base plus index, special cases
// - mod 01/10 add d8/d32, ESP EBP use SS
// - each flag modified, kept, cleared or set
// - two register components add one clock
// - odd 32-bit operand adds one or two
// - non-cached memory operand adds two clocks
// - locked accesses pay non-cached penalty too
// - conditional jump four taken, one not
// - adjust after add: 4 clocks, auxiliary, carry
// - adjust after multiply: 16 clocks, sign zero parity
// - adjust before divide: 4 clocks, sign zero parity
// - privilege adjust protected only, 6/10, zero flag
// - bound check 11 clocks, out raises int5
// - forward scan 5/7 plus n, zero flag
// - complement bit test 4/5 or 5/8, carry
// - calls: near 7, indirect 8/9, far 12/30
`timescale 1ns/1ns
module sad_decode (
    input  wire logic              i_clk,
    input  wire logic              i_nrst,
    input  wire logic              i_valid,
    input  wire sad_pkg::sad_req_t i_req,
    output logic                   o_valid,
    output sad_pkg::sad_rsp_t      o_rsp
);
    import sad_pkg::*;

    sad_rsp_t rsp_d;
    sad_rsp_t rsp_q;
    logic     vld_d;
    logic     vld_q;

    // build flag set from six actions: overflow, sign, zero, aux, parity, carry
    function automatic sad_flags_t mk_flags(input sad_flact_t o, input sad_flact_t s,
        input sad_flact_t z, input sad_flact_t a, input sad_flact_t p, input sad_flact_t c);
        sad_flags_t f;
        f.ovf_a = o;
        f.sgn_a = s;
        f.zro_a = z;
        f.aux_a = a;
        f.par_a = p;
        f.cry_a = c;
        return f;
    endfunction

    // pick register or memory clock count
    function automatic logic [7:0] rm_ck(input logic is_reg, input logic [7:0] r,
        input logic [7:0] m);
        return is_reg ? r : m;
    endfunction

    // address, segment and timing decode
    always_comb begin
        logic [1:0]  md;
        logic [2:0]  rg;
        logic [2:0]  base;
        logic [2:0]  idx;
        logic [1:0]  ss;
        logic        is_reg;
        logic        use_idx;
        logic        use_base;
        logic [31:0] dsp;
        logic [31:0] sidx;
        logic [31:0] bval;
        logic        mem;
        logic [7:0]  ck;
        sad_seg_t    dseg;
        md       = i_req.modrm[7:6];
        rg       = i_req.modrm[5:3];
        ss       = i_req.sib[7:6];
        idx      = i_req.sib[5:3];
        base     = i_req.sib[2:0];
        is_reg   = (md == SAD_MOD_REG);
        mem      = !is_reg;
        use_idx  = (idx != SAD_IDX_NONE);
        use_base = !(md == SAD_MOD_NODSP && base == SAD_BASE_EBP);
        // displacement width by mod: none (d32 when mod 00 has no base), d8 sign-extended, d32
        unique case (md)
            SAD_MOD_D8:  dsp = {{24{i_req.disp[7]}}, i_req.disp[7:0]};
            SAD_MOD_D32: dsp = i_req.disp;
            default:     dsp = use_base ? 32'h0000_0000 : i_req.disp;
        endcase
        sidx = use_idx ? (i_req.index_val << ss) : 32'h0000_0000;
        bval = use_base ? i_req.base_val : 32'h0000_0000;
        // ESP always SS; EBP SS only when it is really a base
        if (base == SAD_BASE_ESP || (base == SAD_BASE_EBP && use_base)) begin
            dseg = SAD_SEG_SS;
        end else begin
            dseg = SAD_SEG_DS;
        end
        rsp_d.eff_addr   = bval + sidx + dsp;
        rsp_d.seg        = i_req.ovr_valid ? i_req.ovr_seg : dseg;
        rsp_d.ea_undef   = mem && !use_idx && (ss != 2'h0);
        rsp_d.raise_int5 = 1'b0;
        rsp_d.op         = SAD_OP_NONE;
        rsp_d.flags      = mk_flags(SAD_FL_KEEP, SAD_FL_KEEP, SAD_FL_KEEP,
                                    SAD_FL_KEEP, SAD_FL_KEEP, SAD_FL_KEEP);
        ck = SAD_RST_CK;
        // opcode classes; flag actions per instruction
        if (i_req.op0 == 8'h37) begin
            rsp_d.op    = SAD_OP_AFADD;
            ck          = SAD_CK_AFADD;
            mem         = 1'b0;
            rsp_d.flags = mk_flags(SAD_FL_KEEP, SAD_FL_KEEP, SAD_FL_KEEP,
                                   SAD_FL_MOD, SAD_FL_KEEP, SAD_FL_MOD);
        end else if (i_req.op0 == 8'hD4 && i_req.op1 == 8'h0A) begin
            rsp_d.op    = SAD_OP_AFMUL;
            ck          = SAD_CK_AFMUL;
            mem         = 1'b0;
            rsp_d.flags = mk_flags(SAD_FL_KEEP, SAD_FL_MOD, SAD_FL_MOD,
                                   SAD_FL_KEEP, SAD_FL_MOD, SAD_FL_KEEP);
        end else if (i_req.op0 == 8'hD5 && i_req.op1 == 8'h0A) begin
            rsp_d.op    = SAD_OP_AFDIV;
            ck          = SAD_CK_AFDIV;
            mem         = 1'b0;
            rsp_d.flags = mk_flags(SAD_FL_KEEP, SAD_FL_MOD, SAD_FL_MOD,
                                   SAD_FL_KEEP, SAD_FL_MOD, SAD_FL_KEEP);
        end else if (i_req.op0 == 8'h63 && i_req.prot_mode) begin
            // real mode leaves this unrecognised
            rsp_d.op    = SAD_OP_RPLADJ;
            ck          = rm_ck(is_reg, SAD_CK_RPL_R, SAD_CK_RPL_M);
            rsp_d.flags = mk_flags(SAD_FL_KEEP, SAD_FL_KEEP, SAD_FL_MOD,
                                   SAD_FL_KEEP, SAD_FL_KEEP, SAD_FL_KEEP);
        end else if (i_req.op0 == 8'h62) begin
            rsp_d.op         = SAD_OP_BOUND;
            ck               = SAD_CK_BOUND;
            rsp_d.raise_int5 = i_req.bound_out;
        end else if (i_req.op0 == 8'h0F && i_req.op1 == 8'hBC) begin
            rsp_d.op    = SAD_OP_FSCAN;
            ck          = rm_ck(is_reg, SAD_CK_SCAN_R, SAD_CK_SCAN_M)
                          + {2'h0, i_req.scan_n};
            rsp_d.flags = mk_flags(SAD_FL_KEEP, SAD_FL_KEEP, SAD_FL_MOD,
                                   SAD_FL_KEEP, SAD_FL_KEEP, SAD_FL_KEEP);
        end else if (i_req.op0 == 8'h0F && i_req.op1 == 8'hBA && rg == 3'h7) begin
            rsp_d.op    = SAD_OP_BCP_IMM;
            ck          = rm_ck(is_reg, SAD_CK_BTCI_R, SAD_CK_BTCI_M);
            rsp_d.flags = mk_flags(SAD_FL_KEEP, SAD_FL_KEEP, SAD_FL_KEEP,
                                   SAD_FL_KEEP, SAD_FL_KEEP, SAD_FL_MOD);
        end else if (i_req.op0 == 8'h0F && i_req.op1 == 8'hBB) begin
            rsp_d.op    = SAD_OP_BCP_REG;
            ck          = rm_ck(is_reg, SAD_CK_BTCR_R, SAD_CK_BTCR_M);
            rsp_d.flags = mk_flags(SAD_FL_KEEP, SAD_FL_KEEP, SAD_FL_KEEP,
                                   SAD_FL_KEEP, SAD_FL_KEEP, SAD_FL_MOD);
        end else if (i_req.op0 == 8'hE8) begin
            rsp_d.op = SAD_OP_CALL_N;
            ck       = SAD_CK_CALLN;
            mem      = 1'b0;
        end else if (i_req.op0 == 8'hFF && rg == 3'h2) begin
            rsp_d.op = SAD_OP_CALL_I;
            ck       = rm_ck(is_reg, SAD_CK_CALLI_R, SAD_CK_CALLI_M);
        end else if (i_req.op0 == 8'h9A) begin
            rsp_d.op = SAD_OP_CALL_F;
            ck       = i_req.prot_mode ? SAD_CK_CALLF_P : SAD_CK_CALLF_R;
            mem      = 1'b0;
        end else if (i_req.op0[7:4] == 4'h7 ||
                     (i_req.op0 == 8'h0F && i_req.op1[7:4] == 4'h8)) begin
            rsp_d.op = SAD_OP_JCC;
            ck       = i_req.br_taken ? SAD_CK_JCC_T : SAD_CK_JCC_N;
            mem      = 1'b0;
        end else begin
            mem = 1'b0;
        end
        // memory-operand adjustments apply only to known memory forms
        if (mem && rsp_d.op != SAD_OP_NONE) begin
            if (use_idx && use_base) begin
                ck = ck + SAD_CK_TWOREG;
            end
            if (i_req.odd_addr) begin
                ck = ck + (i_req.rmw ? SAD_CK_ODD_RMW : SAD_CK_ODD_RW1);
            end
            // locked cycles bypass the cache
            if (!i_req.cache_hit || i_req.locked) begin
                ck = ck + SAD_CK_NOCACHE;
            end
        end
        rsp_d.clocks = ck;
        vld_d        = i_valid;
    end

    // result register; answer one cycle after the request
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rsp_q <= '0;
            vld_q <= 1'b0;
        end else begin
            rsp_q <= rsp_d;
            vld_q <= vld_d;
        end
    end

    assign o_valid = vld_q;
    assign o_rsp   = rsp_q;

endmodule

// ---- verif/sad_decode_sva.sv ----
// Purpose: port checker for the address and flag decoder
// Assumes: answer one cycle after the sampling edge
// Notes:   every check except valid_idle_a is gated by i_valid, so idle request fields are ignored
`timescale 1ns/1ns
module sad_decode_chk (
    input wire logic              i_clk,
    input wire logic              i_nrst,
    input wire logic              i_valid,
    input wire sad_pkg::sad_req_t i_req,
    input wire logic              o_valid,
    input wire sad_pkg::sad_rsp_t o_rsp
);
    import sad_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // one answer per request, none without one
    valid_pulse_a: assert property (i_valid |=> o_valid) else $error("no answer");
    valid_idle_a: assert property (!i_valid |=> !o_valid) else $error("stray answer");
    jcc_time_a: assert property (i_valid && i_req.op0[7:4] == 4'h7 |=>
        o_rsp.clocks == ($past(i_req.br_taken) ? 8'h04 : 8'h01)) else $error("jump time");
    afadd_flags_a: assert property (i_valid && i_req.op0 == 8'h37 |=>
        o_rsp.clocks == 8'h04 && o_rsp.flags == 12'h011) else $error("add adjust");
    afmul_flags_a: assert property (i_valid && i_req.op0 == 8'hD4
        && i_req.op1 == 8'h0A |=> o_rsp.clocks == 8'h10 && o_rsp.flags == 12'h144)
        else $error("mul adjust");
    bound_int_a: assert property (i_valid && i_req.op0 == 8'h62 |=>
        o_rsp.raise_int5 == $past(i_req.bound_out) && o_rsp.clocks >= 8'h0B) else $error("bound");
    seg_ovr_a: assert property (i_valid && i_req.ovr_valid |=>
        o_rsp.seg == $past(i_req.ovr_seg)) else $error("override seg");
    ea_undef_a: assert property (i_valid && i_req.modrm[7:6] != 2'h3
        && i_req.sib[5:3] == 3'h4 && i_req.sib[7:6] != 2'h0 |=> o_rsp.ea_undef)
        else $error("undef flag");
    esp_seg_a: assert property (i_valid && !i_req.ovr_valid && i_req.sib[2:0] == 3'h4
        && i_req.modrm[7:6] != 2'h3 |=> o_rsp.seg == SAD_SEG_SS) else $error("esp seg");
    call_near_a: assert property (i_valid && i_req.op0 == 8'hE8 |=>
        o_rsp.clocks == 8'h07 && o_rsp.flags == '0) else $error("near call");
    c_undef: cover property (o_valid && o_rsp.ea_undef);
    c_jcc: cover property (i_valid && i_req.op0[7:4] == 4'h7 && i_req.br_taken);
    c_ovr: cover property (i_valid && i_req.ovr_valid);
    c_int: cover property (o_valid && o_rsp.raise_int5);
endmodule
bind sad_decode sad_decode_chk chk_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_valid(i_valid),
    .i_req(i_req), .o_valid(o_valid), .o_rsp(o_rsp));

// ---- verif/sad_feed.sv ----
// Purpose: prefetch side model handing one decode request at a time
// Assumes: requests change on the falling edge
// Notes:   idle fields are inverted so a stale request never looks fresh
`timescale 1ns/1ns
module sad_feed (
    input  wire logic         i_clk,
    output logic              o_valid,
    output sad_pkg::sad_req_t o_req
);
    import sad_pkg::*;
    // quiet at time zero
    initial begin
        o_valid = 1'b0;
        o_req = '0;
    end
    // present for exactly one sampling edge
    task automatic issue(input sad_req_t r);
        @(negedge i_clk);
        o_valid = 1'b1;
        o_req = r;
        @(negedge i_clk);
        o_valid = 1'b0;
        o_req = ~r;
    endtask
endmodule

// ---- verif/sad_decode_tb.sv ----
// Purpose: self-checking bench for the address and flag decoder
// Assumes: answer is read at the falling edge after the sampling edge
// Notes:   expected values are worked out here, never from the design
`timescale 1ns/1ns
module sad_decode_tb;
    import sad_pkg::*;
    localparam logic [31:0] BV = 32'hF000_0010;
    localparam logic [31:0] XV = 32'h8000_0123;
    localparam logic [31:0] DV = 32'h1234_5680;
    logic      i_clk;
    logic      i_nrst;
    logic      i_valid;
    sad_req_t  i_req;
    logic      o_valid;
    sad_rsp_t  o_rsp;
    int        failures;
    int        samples_checked;
    sad_decode dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_valid(i_valid), .i_req(i_req),
        .o_valid(o_valid), .o_rsp(o_rsp));
    sad_feed feed_u (.i_clk(i_clk), .o_valid(i_valid), .o_req(i_req));
    // 100 ns core clock
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    // compare one value; unknowns in the seen value count as a mismatch
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ms bits: prot, taken, bound_out, odd, rmw, uncached, locked
    task automatic op_case(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] mr,
        input logic [7:0] sb, input logic [6:0] ms, input int sc, input sad_op_t eo,
        input int ek, input logic [11:0] ef, input int ei);
        sad_req_t r;
        r = '0;
        {r.op0, r.op1, r.modrm, r.sib} = {b0, b1, mr, sb};
        {r.prot_mode, r.br_taken, r.bound_out, r.odd_addr} = ms[6:3];
        // uncached bit is inverted into the hit flag
        {r.rmw, r.cache_hit, r.locked} = ms[2:0] ^ 3'h2;
        r.scan_n = sc[5:0];
        feed_u.issue(r);
        chk(o_valid, 1'b1);
        chk(o_rsp.op, eo);
        chk(o_rsp.clocks, ek);
        chk(o_rsp.flags, ef);
        chk(o_rsp.raise_int5, ei);
    endtask
    // every memory mod (00, 01, 10), base, scale and both index kinds, with wrap-around sums
    task automatic t_addr();
        sad_req_t r;
        logic [31:0] ea;
        for (int m = 0; m < 3; m++) begin
            for (int b = 0; b < 8; b++) begin
                for (int k = 0; k < 8; k++) begin
                    r = '0;
                    {r.op0, r.modrm} = {8'h90, m[1:0], 6'h04};
                    r.sib = {k[1:0], (k[2] ? 3'h4 : 3'h1), b[2:0]};
                    {r.base_val, r.index_val, r.disp} = {BV, XV, DV};
                    feed_u.issue(r);
                    ea = (m == 0 && b == 5) ? '0 : BV;
                    ea = ea + (k[2] ? '0 : XV << k[1:0]);
                    ea = ea + ((m == 1) ? {{24{DV[7]}}, DV[7:0]} : (m == 2 || b == 5) ? DV : '0);
                    chk(o_rsp.eff_addr, ea);
                    chk(o_rsp.seg, (b == 4 || (b == 5 && m != 0)) ? SAD_SEG_SS
                        : SAD_SEG_DS);
                    chk(o_rsp.ea_undef, k[2] && k[1:0] != 2'h0);
                    chk(o_rsp.clocks, 8'h00);
                end
            end
        end
    endtask
    task automatic t_ovr();
        sad_req_t r;
        for (int s = 0; s < 4; s++) begin
            r = '0;
            {r.modrm, r.sib, r.ovr_valid, r.ovr_seg} = {8'h04, 8'h24, 1'b1, sad_seg_t'(s)};
            feed_u.issue(r);
            chk(o_rsp.seg, s);
        end
    endtask
    task automatic t_ops();
        op_case(8'h37, 8'h00, 8'hC0, 8'h00, 7'h00, 0, SAD_OP_AFADD, 4, 12'h011, 0);
        op_case(8'hD4, 8'h0A, 8'hC0, 8'h00, 7'h00, 0, SAD_OP_AFMUL, 16, 12'h144, 0);
        op_case(8'hD5, 8'h0A, 8'hC0, 8'h00, 7'h00, 0, SAD_OP_AFDIV, 4, 12'h144, 0);
        op_case(8'h63, 8'h00, 8'hC0, 8'h00, 7'h40, 0, SAD_OP_RPLADJ, 6, 12'h040, 0);
        op_case(8'h63, 8'h00, 8'hC0, 8'h00, 7'h00, 0, SAD_OP_NONE, 0, 12'h000, 0);
        op_case(8'h62, 8'h00, 8'hC0, 8'h00, 7'h10, 0, SAD_OP_BOUND, 11, 12'h000, 1);
        op_case(8'h62, 8'h00, 8'hC0, 8'h00, 7'h00, 0, SAD_OP_BOUND, 11, 12'h000, 0);
        op_case(8'h0F, 8'hBC, 8'hC0, 8'h00, 7'h00, 3, SAD_OP_FSCAN, 8, 12'h040, 0);
        op_case(8'h0F, 8'hBA, 8'hF8, 8'h00, 7'h00, 0, SAD_OP_BCP_IMM, 4, 12'h001, 0);
        op_case(8'h0F, 8'hBB, 8'hC0, 8'h00, 7'h00, 0, SAD_OP_BCP_REG, 5, 12'h001, 0);
        op_case(8'hE8, 8'h00, 8'hC0, 8'h00, 7'h00, 0, SAD_OP_CALL_N, 7, 12'h000, 0);
        op_case(8'hFF, 8'h00, 8'hD0, 8'h00, 7'h00, 0, SAD_OP_CALL_I, 8, 12'h000, 0);
        op_case(8'h9A, 8'h00, 8'hC0, 8'h00, 7'h00, 0, SAD_OP_CALL_F, 12, 12'h000, 0);
        op_case(8'h9A, 8'h00, 8'hC0, 8'h00, 7'h40, 0, SAD_OP_CALL_F, 30, 12'h000, 0);
        op_case(8'h74, 8'h00, 8'hC0, 8'h00, 7'h20, 0, SAD_OP_JCC, 4, 12'h000, 0);
        op_case(8'h0F, 8'h84, 8'hC0, 8'h00, 7'h00, 0, SAD_OP_JCC, 1, 12'h000, 0);
    endtask
    // memory forms, some stacking the clock penalties and some with none
    task automatic t_mem();
        op_case(8'h0F, 8'hBB, 8'h04, 8'h08, 7'h0E, 0,
                SAD_OP_BCP_REG, 13, 12'h001, 0);
        op_case(8'h0F, 8'hBB, 8'h04, 8'h20, 7'h09, 0,
                SAD_OP_BCP_REG, 11, 12'h001, 0);
        op_case(8'hFF, 8'h00, 8'h14, 8'h20, 7'h00, 0, SAD_OP_CALL_I, 9, 12'h000, 0);
        op_case(8'h0F, 8'hBC, 8'h04, 8'h08, 7'h00, 0, SAD_OP_FSCAN, 8, 12'h040, 0);
        op_case(8'h63, 8'h00, 8'h04, 8'h20, 7'h40, 0, SAD_OP_RPLADJ, 10, 12'h040, 0);
        op_case(8'h0F, 8'hBA, 8'h3C, 8'h20, 7'h00, 0, SAD_OP_BCP_IMM, 5, 12'h001, 0);
    endtask
    // reset in mid-run clears the answer at once
    task automatic t_rst();
        op_case(8'hE8, 8'h00, 8'hC0, 8'h00, 7'h00, 0, SAD_OP_CALL_N, 7, 12'h000, 0);
        i_nrst = 1'b0;
        #1;
        chk(o_valid, 1'b0);
        chk(o_rsp.clocks, 8'h00);
        @(negedge i_clk);
        i_nrst = 1'b1;
    endtask
    // main sequence
    initial begin
        failures = 0;
        samples_checked = 0;
        i_nrst = 1'b0;
        repeat (12) @(negedge i_clk);
        i_nrst = 1'b1;
        t_addr();
        t_ovr();
        t_ops();
        t_mem();
        t_rst();
        t_ops();
        wrap_up();
    end
    // hang guard, well beyond the few hundred cycles needed
    initial begin
        #200000;
        failures++;
        wrap_up();
    end
endmodule
